// File: src/aec_pkg.sv
// constants shared by the event counter pair
package aec_pkg;
   localparam logic [1:0] CKS_PIN = 2'h0;
   localparam logic [1:0] CKS_DIV2 = 2'h1;
   localparam logic [1:0] CKS_DIV4 = 2'h2;
   localparam logic [1:0] CKS_DIV8 = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam int CNT_W = 8;
   localparam int PWM_W = 16;
   localparam int PRESC_W = 6;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [15:0] PWM_RST = 16'h0000;
   typedef enum logic [1:0] {AEC_ACTIVE, AEC_LOWPWR_PIN, AEC_SUB, AEC_MSTBY} aec_mode_t;
endpackage

// File: src/aec_edge_sense.sv
// synchroniser plus selectable edge detector for one pin
`timescale 1ns/10ps
module aec_edge_sense (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   output logic level,
   output logic hit
);
   logic s1_reg, s2_reg, s3_reg;
   logic s1_next, s2_next, s3_next, hit_next;
   logic hit_reg;
   logic [2:0] live_reg, live_next;

   always_comb begin
      s1_next = pin;
      s2_next = s1_reg;
      s3_next = s2_reg;
      live_next = {live_reg[1:0], 1'b1};
      case (edge_sel) // RULE25
         aec_pkg::EDGE_FALL: hit_next = s3_reg & ~s2_reg;
         aec_pkg::EDGE_RISE: hit_next = ~s3_reg & s2_reg;
         aec_pkg::EDGE_BOTH: hit_next = s3_reg ^ s2_reg;
         default: hit_next = 1'b0;
      endcase
      // stages still hold reset zeros, so an idle-high pin would look like a rising edge
      if (!live_reg[2]) hit_next = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         hit_reg <= 1'b0;
         live_reg <= 3'h0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         hit_reg <= hit_next;
         live_reg <= live_next;
      end
   end

   assign level = s2_reg;
   assign hit = hit_reg;
endmodule

// File: src/aec_counter_pair.sv
// event counter pair with gating, gate pwm and overflow flags
// Operation
// RULE1 - mode 0 chains halves into 16 bits
// RULE2 - lower source: pin or sysclk/2/4/8
// RULE3 - pin edges counted per edge select
// RULE4 - count only while gate is high
// RULE5 - 16-bit wrap sets upper overflow flag
// RULE6 - any overflow sets counter irq flag
// RULE7 - mode 1 runs halves independently
// RULE8 - each pin uses its own edge select
// RULE9 - 8-bit wrap sets own overflow flag
// RULE10 - pwm select 0 gates by gate pin
// RULE11 - gate edges set gate irq flag
// RULE12 - gate irq edge per gate select
// RULE13 - pwm select 1 gates by pwm
// RULE14 - pwm period compare+1, off data+1
// RULE15 - software keeps data below compare
// RULE16 - gating may lose one count
// RULE17 - watch/standby count, flags untouched
// RULE18 - low power counts only pin sources
// RULE19 - watch/standby gate works, no irq
// RULE20 - module standby halts everything
// RULE21 - software stops counting before reading
// RULE22 - software sets upper enable first
// RULE23 - software stops pwm before reloading
// RULE24 - clock select 00 pin, 01/10/11 dividers
// RULE25 - edge select fall, rise, both
// RULE26 - pwm clock divide 2 to 64
// RULE27 - flags set by hardware, cleared read-then-zero
// RULE28 - pwm low first then high
// RULE29 - gate irq set after synchronising
`timescale 1ns/10ps
module aec_counter_pair (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic lower_event_pin,
   input wire logic upper_event_pin,
   input wire logic gate_pin,
   input wire aec_pkg::aec_mode_t power_mode,
   input wire logic pair_mode_select,
   input wire logic upper_count_enable,
   input wire logic lower_count_enable,
   input wire logic upper_reset_release,
   input wire logic lower_reset_release,
   input wire logic lower_clock_select_hi,
   input wire logic lower_clock_select_lo,
   input wire logic upper_clock_select_hi,
   input wire logic upper_clock_select_lo,
   input wire logic [1:0] lower_edge_select,
   input wire logic [1:0] upper_edge_select,
   input wire logic gate_edge_select_hi,
   input wire logic gate_edge_select_lo,
   input wire logic gate_pwm_select,
   input wire logic [2:0] pwm_clock_select,
   input wire logic [15:0] pwm_period_compare,
   input wire logic [15:0] pwm_off_data,
   input wire logic flag_read,
   input wire logic flag_write,
   input wire logic upper_ovf_wdata,
   input wire logic lower_ovf_wdata,
   input wire logic counter_irq_clear,
   input wire logic gate_irq_clear,
   input wire logic counter_irq_enable,
   input wire logic gate_irq_enable,
   output logic [7:0] upper_counter,
   output logic [7:0] lower_counter,
   output logic upper_overflow_flag,
   output logic lower_overflow_flag,
   output logic counter_irq_flag,
   output logic gate_irq_flag,
   output logic counter_irq,
   output logic gate_irq,
   output logic gating_pwm_output
);
   // shared prescaler for every divided source
   logic [aec_pkg::PRESC_W-1:0] presc_reg, presc_next, presc_prev_reg;
   logic [7:0] ecl_reg, ecl_next, ech_reg, ech_next;
   logic ovh_reg, ovh_next, ovl_reg, ovl_next;
   logic ovh_seen_reg, ovh_seen_next, ovl_seen_reg, ovl_seen_next;
   logic cirq_reg, cirq_next, girq_reg, girq_next;
   logic cint_reg, cint_next, gint_reg, gint_next;
   logic [15:0] pwm_cnt_reg, pwm_cnt_next;
   logic pwm_out_reg, pwm_out_next;
   logic gate_prev_reg, gate_prev_next;
   logic lo_hit, hi_hit, gp_lvl, gp_hit;
   logic [1:0] lo_cks, hi_cks, gate_es;
   logic [5:0] tick;
   logic pwm_tick, lo_clk, hi_clk, gate_open, lo_ovf, hi_ovf, hi_in;
   logic gate_evt, count_sync, flags_live, pwm_run, gate_irq_live;

   assign lo_cks = {lower_clock_select_hi, lower_clock_select_lo};
   assign hi_cks = {upper_clock_select_hi, upper_clock_select_lo};
   assign gate_es = {gate_edge_select_hi, gate_edge_select_lo};

   aec_edge_sense u_lo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(lower_event_pin),
      .edge_sel(lower_edge_select), // RULE8
      .level(),
      .hit(lo_hit)
   );
   aec_edge_sense u_hi (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(upper_event_pin),
      .edge_sel(upper_edge_select), // RULE8
      .level(),
      .hit(hi_hit)
   );
   aec_edge_sense u_gate (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(gate_pin),
      .edge_sel(gate_es),
      .level(gp_lvl),
      .hit(gp_hit)
   );
   // divide ticks: bit k pulses on sysclk/2^(k+1)
   genvar gi;
   generate
      for (gi = 0; gi < aec_pkg::PRESC_W; gi++) begin : g_tick
         assign tick[gi] = presc_reg[gi] & ~presc_prev_reg[gi];
      end
   endgenerate

   always_comb begin
      case (pwm_clock_select) // RULE26
         3'h0: pwm_tick = tick[0];
         3'h1: pwm_tick = tick[1];
         3'h2: pwm_tick = tick[2];
         3'h3: pwm_tick = tick[3];
         3'h4, 3'h6: pwm_tick = tick[4];
         default: pwm_tick = tick[5];
      endcase
   end

   // divided sources stop outside active/sleep; pin sources keep counting except in module standby
   assign count_sync = (power_mode == aec_pkg::AEC_ACTIVE); // RULE18
   assign flags_live = (power_mode == aec_pkg::AEC_ACTIVE) || (power_mode == aec_pkg::AEC_SUB); // RULE17
   assign gate_irq_live = flags_live; // RULE19
   assign pwm_run = gate_pwm_select && count_sync;

   // gate level: pin when pwm off, pwm output when on; both counters share it
   assign gate_open = gate_pwm_select ? pwm_out_reg : gp_lvl; // RULE10 RULE13 RULE4

   always_comb begin
      case (lo_cks) // RULE2 RULE24
         aec_pkg::CKS_PIN: lo_clk = lo_hit; // RULE3
         aec_pkg::CKS_DIV2: lo_clk = tick[0] & count_sync;
         aec_pkg::CKS_DIV4: lo_clk = tick[1] & count_sync;
         default: lo_clk = tick[2] & count_sync;
      endcase
      case (hi_cks) // RULE7 RULE24
         aec_pkg::CKS_PIN: hi_clk = hi_hit; // RULE3
         aec_pkg::CKS_DIV2: hi_clk = tick[0] & count_sync;
         aec_pkg::CKS_DIV4: hi_clk = tick[1] & count_sync;
         default: hi_clk = tick[2] & count_sync;
      endcase
   end

   // a gate edge cuts a tick in flight, hence at most one count of error
   assign lo_ovf = lo_clk && gate_open && lower_count_enable && lower_reset_release && (ecl_reg == 8'hFF); // RULE16
   assign hi_in = pair_mode_select ? (hi_clk && gate_open) : lo_ovf; // RULE1 RULE7
   assign hi_ovf = hi_in && upper_count_enable && upper_reset_release && (ech_reg == 8'hFF);
   // pwm edge taken from registered output, so no loop back through the next-state logic
   assign gate_evt = gate_pwm_select ? (pwm_out_reg != gate_prev_reg) && (gate_es == aec_pkg::EDGE_BOTH ||
      (gate_es == aec_pkg::EDGE_RISE) == pwm_out_reg) : gp_hit; // RULE12

   always_comb begin
      presc_next = (power_mode == aec_pkg::AEC_MSTBY) ? presc_reg : presc_reg + 6'h01;
      ecl_next = ecl_reg;
      ech_next = ech_reg;
      ovh_next = ovh_reg;
      ovl_next = ovl_reg;
      ovh_seen_next = ovh_seen_reg | (flag_read & ovh_reg);
      ovl_seen_next = ovl_seen_reg | (flag_read & ovl_reg);
      cirq_next = cirq_reg;
      girq_next = girq_reg;
      pwm_cnt_next = pwm_cnt_reg;
      pwm_out_next = pwm_out_reg;
      gate_prev_next = pwm_out_reg;
      // read-then-write-zero clear; a same-cycle set still wins
      if (flag_write && !upper_ovf_wdata && ovh_seen_reg) begin // RULE27
         ovh_next = 1'b0;
         ovh_seen_next = 1'b0;
      end
      if (flag_write && !lower_ovf_wdata && ovl_seen_reg) begin // RULE27
         ovl_next = 1'b0;
         ovl_seen_next = 1'b0;
      end
      if (counter_irq_clear) cirq_next = 1'b0;
      if (gate_irq_clear) girq_next = 1'b0;
      if (power_mode != aec_pkg::AEC_MSTBY) begin // RULE20
         if (!lower_reset_release) begin
            ecl_next = aec_pkg::CNT_RST;
         end else if (lo_clk && gate_open && lower_count_enable) begin
            ecl_next = ecl_reg + 8'h01; // RULE5 RULE9
         end
         if (!upper_reset_release) begin
            ech_next = aec_pkg::CNT_RST;
         end else if (hi_in && upper_count_enable) begin
            ech_next = ech_reg + 8'h01; // RULE5 RULE9
         end
         if (flags_live) begin // RULE17
            if (hi_ovf) begin
               ovh_next = 1'b1; // RULE5 RULE9
               cirq_next = 1'b1; // RULE6
            end
            if (lo_ovf && pair_mode_select) begin
               ovl_next = 1'b1; // RULE9
               cirq_next = 1'b1; // RULE6
            end
         end
         if (gate_evt && gate_irq_live) girq_next = 1'b1; // RULE11 RULE29
         if (!gate_pwm_select) begin
            pwm_cnt_next = aec_pkg::PWM_RST;
            pwm_out_next = 1'b0;
         end else if (pwm_run && pwm_tick) begin
            // low for data+1 ticks, then high until compare, then restart
            if (pwm_cnt_reg >= pwm_period_compare) begin // RULE14 RULE28
               pwm_cnt_next = aec_pkg::PWM_RST;
               pwm_out_next = 1'b0;
            end else begin
               pwm_cnt_next = pwm_cnt_reg + 16'h0001;
               pwm_out_next = (pwm_cnt_reg >= pwm_off_data); // RULE14 RULE28
            end
         end
      end
      cint_next = cirq_next & counter_irq_enable; // RULE6
      gint_next = girq_next & gate_irq_enable; // RULE11
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         presc_reg <= '0;
         presc_prev_reg <= '0;
         ecl_reg <= aec_pkg::CNT_RST;
         ech_reg <= aec_pkg::CNT_RST;
         ovh_reg <= 1'b0;
         ovl_reg <= 1'b0;
         ovh_seen_reg <= 1'b0;
         ovl_seen_reg <= 1'b0;
         cirq_reg <= 1'b0;
         girq_reg <= 1'b0;
         cint_reg <= 1'b0;
         gint_reg <= 1'b0;
         pwm_cnt_reg <= aec_pkg::PWM_RST;
         pwm_out_reg <= 1'b0;
         gate_prev_reg <= 1'b0;
      end else begin
         presc_reg <= presc_next;
         presc_prev_reg <= presc_reg;
         ecl_reg <= ecl_next;
         ech_reg <= ech_next;
         ovh_reg <= ovh_next;
         ovl_reg <= ovl_next;
         ovh_seen_reg <= ovh_seen_next;
         ovl_seen_reg <= ovl_seen_next;
         cirq_reg <= cirq_next;
         girq_reg <= girq_next;
         cint_reg <= cint_next;
         gint_reg <= gint_next;
         pwm_cnt_reg <= pwm_cnt_next;
         pwm_out_reg <= pwm_out_next;
         gate_prev_reg <= gate_prev_next;
      end
   end

   assign upper_counter = ech_reg;
   assign lower_counter = ecl_reg;
   assign upper_overflow_flag = ovh_reg;
   assign lower_overflow_flag = ovl_reg;
   assign counter_irq_flag = cirq_reg;
   assign gate_irq_flag = girq_reg;
   assign counter_irq = cint_reg;
   assign gate_irq = gint_reg;
   assign gating_pwm_output = pwm_out_reg;

   sequence s_lo_wrap;
      lo_ovf && pair_mode_select && flags_live && power_mode != aec_pkg::AEC_MSTBY;
   endsequence

   a_lo_wrap_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE9
      s_lo_wrap |=> lower_overflow_flag && counter_irq_flag && lower_counter == 8'h00)
      else $error("lower wrap did not set flag");
   a_chain_wrap: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE5
      (hi_ovf && !pair_mode_select && flags_live && power_mode != aec_pkg::AEC_MSTBY)
      |=> upper_overflow_flag && upper_counter == 8'h00 && lower_counter == 8'h00)
      else $error("16-bit wrap wrong");
   a_gate_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE4
      (!gate_open && lower_reset_release) |=> $stable(lower_counter))
      else $error("counter moved while gated");
   a_mstby_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE20
      (power_mode == aec_pkg::AEC_MSTBY) |=> $stable(upper_counter) && $stable(lower_counter))
      else $error("counter moved in module standby");
   a_flag_keep: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE27
      (upper_overflow_flag && !flag_write) |=> upper_overflow_flag)
      else $error("overflow flag dropped");
   a_cirq_out: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE6
      (counter_irq_flag && counter_irq_enable) |=> counter_irq || !counter_irq_flag)
      else $error("counter irq not raised");
   a_pwm_low_start: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE28
      (pwm_tick && pwm_run && pwm_cnt_reg >= pwm_period_compare) |=> !gating_pwm_output)
      else $error("pwm period did not restart low");
   a_lowpwr_flags: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE17
      (!flags_live && !flag_write) |=> $stable(upper_overflow_flag) && $stable(lower_overflow_flag))
      else $error("flag changed in watch or standby");
endmodule

// File: dv/aec_event_src.sv
// event pin and gate pin source standing in front of the counter pair
`timescale 1ns/10ps
module aec_event_src (
   input wire logic sys_clk,
   output logic lower_event_pin,
   output logic upper_event_pin,
   output logic gate_pin
);
   // pins idle high so the default falling sense sees nothing at rest
   initial begin
      lower_event_pin = 1'b1;
      upper_event_pin = 1'b1;
      gate_pin = 1'b1;
   end

   // n low-high pulses, w clocks per phase; w of 1 is the fastest the synchroniser takes
   task automatic pulse(input bit up, input int n, input int w);
      repeat (n) begin
         @(posedge sys_clk);
         if (up) upper_event_pin <= 1'b0;
         else lower_event_pin <= 1'b0;
         repeat (w) @(posedge sys_clk);
         if (up) upper_event_pin <= 1'b1;
         else lower_event_pin <= 1'b1;
         repeat (w - 1) @(posedge sys_clk);
      end
   endtask

   task automatic gate(input logic v);
      @(posedge sys_clk);
      gate_pin <= v;
   endtask
endmodule

// File: dv/aec_counter_pair_tb_top.sv
// self-checking bench for the event counter pair
`timescale 1ns/10ps
module aec_counter_pair_tb_top;
   typedef struct {logic md; logic [1:0] le, ue; int nl, nh; logic [7:0] el, eh;} aec_row_t;
   logic sys_clk, nrst, lower_event_pin, upper_event_pin, gate_pin;
   aec_pkg::aec_mode_t power_mode;
   logic pair_mode_select, upper_count_enable, lower_count_enable, upper_reset_release, lower_reset_release;
   logic lower_clock_select_hi, lower_clock_select_lo, upper_clock_select_hi, upper_clock_select_lo;
   logic [1:0] lower_edge_select, upper_edge_select;
   logic gate_edge_select_hi, gate_edge_select_lo, gate_pwm_select;
   logic [2:0] pwm_clock_select;
   logic [15:0] pwm_period_compare, pwm_off_data;
   logic flag_read, flag_write, upper_ovf_wdata, lower_ovf_wdata, counter_irq_clear, gate_irq_clear;
   logic counter_irq_enable, gate_irq_enable;
   logic [7:0] upper_counter, lower_counter;
   logic upper_overflow_flag, lower_overflow_flag, counter_irq_flag, gate_irq_flag, counter_irq, gate_irq;
   logic gating_pwm_output;
   int fails, comparisons, hi, dv;
   aec_row_t rows[6];

   aec_counter_pair u_aec_counter_pair (.*);
   aec_event_src u_aec_event_src (.*);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // enables rise before the release so the upper half never misses a carry
   task automatic clr;
      @(posedge sys_clk);
      {upper_reset_release, lower_reset_release, upper_count_enable, lower_count_enable} <= 4'h3;
      tick(2);
      {upper_reset_release, lower_reset_release} <= 2'h3;
   endtask

   // counting stopped before any read so an event cannot land mid-compare
   task automatic halt;
      tick(6);
      {upper_count_enable, lower_count_enable} <= 2'h0;
      tick(2);
   endtask

   task automatic gclr;
      gate_irq_clear <= 1'b1;
      tick(1);
      gate_irq_clear <= 1'b0;
   endtask

   task automatic wrap(input aec_pkg::aec_mode_t m, input logic f);
      power_mode <= m;
      pair_mode_select <= 1'b1;
      {lower_clock_select_hi, lower_clock_select_lo} <= aec_pkg::CKS_PIN;
      lower_edge_select <= aec_pkg::EDGE_FALL;
      clr;
      u_aec_event_src.pulse(1'b0, 256, 1);
      halt;
      chk("lower_counter", lower_counter, 16'h0000);
      chk("lower_overflow_flag", lower_overflow_flag, f);
      chk("upper_overflow_flag", upper_overflow_flag, 16'h0000);
      if (f) chk("counter_irq", counter_irq, 16'h0001);
   endtask

   task automatic wrap_up;
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      tick(30000);
      fails++;
      wrap_up;
   end

   initial begin
      rows = '{'{1'b0, 2'h0, 2'h0, 5, 0, 8'h05, 8'h00}, '{1'b0, 2'h1, 2'h0, 4, 3, 8'h04, 8'h00},
               '{1'b0, 2'h2, 2'h1, 3, 2, 8'h06, 8'h00}, '{1'b1, 2'h3, 2'h1, 4, 6, 8'h00, 8'h06},
               '{1'b1, 2'h1, 2'h0, 2, 7, 8'h02, 8'h07}, '{1'b1, 2'h0, 2'h2, 1, 2, 8'h01, 8'h04}};
      nrst = 1'b0;
      power_mode = aec_pkg::AEC_ACTIVE;
      {pair_mode_select, upper_count_enable, lower_count_enable, upper_reset_release, lower_reset_release} = '0;
      {lower_clock_select_hi, lower_clock_select_lo, upper_clock_select_hi, upper_clock_select_lo} = '0;
      {lower_edge_select, upper_edge_select, gate_edge_select_hi, gate_edge_select_lo, gate_pwm_select} = '0;
      {pwm_clock_select, pwm_period_compare, pwm_off_data, flag_read, flag_write} = '0;
      {upper_ovf_wdata, lower_ovf_wdata, counter_irq_clear, gate_irq_clear, counter_irq_enable, gate_irq_enable} = 6'h03;
      tick(10);
      nrst <= 1'b1;
      tick(2);
      chk("counters", {upper_counter, lower_counter}, 16'h0000);
      chk("flags", 16'({upper_overflow_flag, lower_overflow_flag, counter_irq_flag, gate_irq_flag,
                        counter_irq, gate_irq, gating_pwm_output}), 16'h0000);
      foreach (rows[i]) begin
         pair_mode_select <= rows[i].md;
         lower_edge_select <= rows[i].le;
         upper_edge_select <= rows[i].ue;
         clr;
         u_aec_event_src.pulse(1'b0, rows[i].nl, 2);
         u_aec_event_src.pulse(1'b1, rows[i].nh, 2);
         halt;
         chk("lower_counter", lower_counter, rows[i].el);
         chk("upper_counter", upper_counter, rows[i].eh);
      end
      // gate pin low holds the lower half
      u_aec_event_src.gate(1'b0);
      clr;
      tick(4);
      u_aec_event_src.pulse(1'b0, 3, 2);
      halt;
      chk("lower_counter", lower_counter, 16'h0000);
      u_aec_event_src.gate(1'b1);
      clr;
      power_mode <= aec_pkg::AEC_MSTBY;
      u_aec_event_src.pulse(1'b0, 3, 2);
      halt;
      chk("lower_counter", lower_counter, 16'h0000);
      power_mode <= aec_pkg::AEC_ACTIVE;
      // divided sources: prescaler phase is free, so one count of slack
      for (int d = 1; d < 4; d++) begin
         {lower_clock_select_hi, lower_clock_select_lo} <= d[1:0];
         {upper_clock_select_hi, upper_clock_select_lo} <= d[1:0];
         clr;
         tick(96);
         {upper_count_enable, lower_count_enable} <= 2'h0;
         tick(2);
         hi = 96 >> d;
         chk("lower div", 16'(lower_counter >= hi - 1 && lower_counter <= hi + 1), 16'h0001);
         chk("upper div", 16'(upper_counter >= hi - 1 && upper_counter <= hi + 1), 16'h0001);
      end
      clr;
      power_mode <= aec_pkg::AEC_SUB;
      tick(64);
      halt;
      chk("lower sub", 16'(lower_counter <= 1), 16'h0001);
      wrap(aec_pkg::AEC_ACTIVE, 1'b1);
      {flag_write, counter_irq_enable} <= 2'h2;
      tick(1);
      flag_write <= 1'b0;
      tick(2);
      chk("lower_overflow_flag", lower_overflow_flag, 16'h0001);
      chk("counter_irq", 16'({counter_irq_flag, counter_irq}), 16'h0002);
      {flag_read, counter_irq_enable} <= 2'h3;
      tick(1);
      // writing 1 after the read must not clear
      {flag_read, flag_write, lower_ovf_wdata} <= 3'h3;
      tick(1);
      chk("lower_overflow_flag", lower_overflow_flag, 16'h0001);
      {flag_write, lower_ovf_wdata, counter_irq_clear} <= 3'h5;
      tick(1);
      {flag_write, counter_irq_clear} <= 2'h0;
      tick(3);
      chk("lower_overflow_flag", lower_overflow_flag, 16'h0000);
      chk("counter_irq", 16'({counter_irq_flag, counter_irq}), 16'h0000);
      wrap(aec_pkg::AEC_LOWPWR_PIN, 1'b0);
      power_mode <= aec_pkg::AEC_ACTIVE;
      pair_mode_select <= 1'b0;
      clr;
      u_aec_event_src.pulse(1'b0, 256, 1);
      halt;
      chk("counter pair", {upper_counter, lower_counter}, 16'h0100);
      chk("lower_overflow_flag", lower_overflow_flag, 16'h0000);
      // upper half alone on sysclk/2 runs past 0xFF
      pair_mode_select <= 1'b1;
      {upper_clock_select_hi, upper_clock_select_lo} <= aec_pkg::CKS_DIV2;
      clr;
      tick(520);
      halt;
      chk("upper flags", 16'({upper_overflow_flag, counter_irq_flag}), 16'h0003);
      chk("upper wrap", 16'(upper_counter >= 8'h05 && upper_counter <= 8'h08), 16'h0001);
      for (int c = 0; c < 3; c++) begin
         {gate_edge_select_hi, gate_edge_select_lo} <= c[1:0];
         gclr;
         u_aec_event_src.gate(1'b0);
         tick(6);
         chk("gate_irq", 16'({gate_irq_flag, gate_irq}), c != 1 ? 16'h0003 : 16'h0000);
         gclr;
         u_aec_event_src.gate(1'b1);
         tick(6);
         chk("gate_irq_flag", gate_irq_flag, 16'(c != 0));
      end
      power_mode <= aec_pkg::AEC_LOWPWR_PIN;
      gclr;
      u_aec_event_src.gate(1'b0);
      tick(6);
      chk("gate_irq_flag", gate_irq_flag, 16'h0000);
      u_aec_event_src.gate(1'b1);
      tick(6);
      power_mode <= aec_pkg::AEC_ACTIVE;
      // data below compare, and only reloaded while stopped
      pwm_period_compare <= 16'h0009;
      pwm_off_data <= 16'h0003;
      for (int p = 0; p < 8; p++) begin
         gate_pwm_select <= 1'b0;
         pwm_clock_select <= p[2:0];
         tick(2);
         gate_pwm_select <= 1'b1;
         tick(4);
         chk("gating_pwm_output", gating_pwm_output, 16'h0000);
         dv = (p < 4) ? (2 << p) : (p[0] ? 64 : 32);
         tick(10 * dv);
         hi = 0;
         repeat (20 * dv) begin
            @(posedge sys_clk);
            hi += int'(gating_pwm_output === 1'b1);
         end
         chk("pwm high cycles", 16'(hi), 16'(12 * dv));
      end
      chk("gate_irq_flag", gate_irq_flag, 16'h0001);
      wrap_up;
   end
endmodule
